// >>> src/mode_ctl_consts.svh
// Purpose: Shared constants for the alt-mode switch pin control block.
// Assumes: 250 MHz core clock; four-level straps arrive pre-digitised as 2-bit codes.
// Notes:   Definitions only.
`ifndef MODE_CTL_CONSTS_SVH
`define MODE_CTL_CONSTS_SVH

// ----------------------------------------------------------------
// Four-level strap codes
// ----------------------------------------------------------------
`define LVL_ZERO       2'h0
`define LVL_R          2'h1
`define LVL_F          2'h2
`define LVL_ONE        2'h3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_PS  32'h0000_0FA0
`define HPD_LOW_US     32'h0000_07D0
// Microseconds to picoseconds, then to clock cycles
`define HPD_LOW_CYC    ((`HPD_LOW_US * 32'h0000_03E8 * 32'h0000_03E8) / `CLK_PERIOD_PS)

// ----------------------------------------------------------------
// Gain code widths and mapping
// ----------------------------------------------------------------
`define GAIN_W         4
`define GAIN_MAX_USB_UP 4'hB

`endif

// >>> src/mode_ctl_pkg.sv
// Purpose: Types for the alt-mode switch pin control block.
// Assumes: Constants come from mode_ctl_consts.svh.
// Notes:   Types only.
`default_nettype none
package mode_ctl_pkg;
	typedef logic [1:0] level_t;   // Four-level strap code
	typedef logic [3:0] gain_t;    // Equalizer gain index
	// Bus mode derived from the interface-select strap
	typedef enum logic [3:0] {
		MODE_PIN    = 4'b0001,
		MODE_TEST   = 4'b0010,
		MODE_BUS_18 = 4'b0100,
		MODE_BUS_33 = 4'b1000
	} bus_mode_e;
endpackage : mode_ctl_pkg
`default_nettype wire

// >>> src/hpd_qualifier.sv
// Purpose: Qualifies a sustained low on the synchronised hot-plug-detect level.
// Assumes: Input already synchronised to clk_i.
// Notes:   Expired flag stays set until the level returns high.
`timescale 1ns/1ps
`include "mode_ctl_consts.svh"
`default_nettype none
module hpd_qualifier #(
	parameter int unsigned LOW_CYC = `HPD_LOW_CYC
) (
	input  wire logic clk_i,
	input  wire logic nrst_i,
	input  wire logic hpd_sync_i,
	output logic      hpd_lost_o
);
	// ----------------------------------------------------------------
	// Low-time counter
	// ----------------------------------------------------------------
	logic [31:0] low_cnt_reg;   // Cycles spent low so far

	// Count while low, restart as soon as the level comes back high
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			low_cnt_reg <= 32'h0000_0000;
		end else if (hpd_sync_i) begin
			low_cnt_reg <= 32'h0000_0000;
		end else if (low_cnt_reg <= 32'(LOW_CYC)) begin
			low_cnt_reg <= low_cnt_reg + 32'h0000_0001;
		end
	end

	// Lost once the low count reaches the limit
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			hpd_lost_o <= 1'b0;
		end else begin
			hpd_lost_o <= !hpd_sync_i && (low_cnt_reg >= 32'(LOW_CYC));
		end
	end

	property p_hpd_restart;
		@(posedge clk_i) disable iff (!nrst_i)
		hpd_sync_i |=> !hpd_lost_o;
	endproperty
	a_hpd_restart: assert property (p_hpd_restart) else $error("lost flag after high hpd");
endmodule : hpd_qualifier
`default_nettype wire

// >>> src/alt_mode_switch_pin_control.sv
// Functional notes
// - Enable rising edge samples all straps
// - Enable gates device only in pin mode
// - Decode interface select into four modes
// - Long hot-plug low disables DisplayPort lanes
// - Flip pin in pin mode, clock otherwise
// - Switch pin in pin mode, data otherwise
// - DisplayPort enable pin in pin mode
// - Bus mode: DisplayPort enable from registers
// - Equalizer straps give bus address bits
// - Upstream gain from two straps, 11 dB max
// - DisplayPort gain from two straps
// - Downstream gain from two straps
// - AUX routed to sideband pins by orientation
//
// Purpose: Pin-level control of an alt-mode crosspoint redriver.
// Assumes: Straps come in as 2-bit four-level codes; serial bus core is outside.
// Notes:   All pin inputs are double synchronised before use.
`timescale 1ns/1ps
`include "mode_ctl_consts.svh"
`default_nettype none
module alt_mode_switch_pin_control
	import mode_ctl_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        nrst_i,
	input  wire logic        enable_i,                        // Device enable pin
	input  wire logic [1:0]  bus_select_i,                    // Interface-select strap
	input  wire logic [1:0]  usb_up_eq_sel_hi_i,
	input  wire logic [1:0]  usb_up_eq_sel_lo_i,
	input  wire logic [1:0]  dp_rx_eq_sel_hi_i,
	input  wire logic [1:0]  dp_rx_eq_sel_lo_addr_b1_i,
	input  wire logic [1:0]  usb_down_eq_sel_hi_i,
	input  wire logic [1:0]  usb_down_eq_sel_lo_addr_b0_i,
	input  wire logic        flip_or_bus_clock_i,             // Shared flip / clock pin
	input  wire logic        usb_switch_or_bus_data_i,        // Shared switch / data pin
	input  wire logic        dp_function_enable_i,            // DisplayPort enable pin
	input  wire logic        hot_plug_detect_in_i,
	input  wire logic        reg_dp_enable_i,                 // From bus-written registers
	input  wire logic        reg_flip_i,                      // Orientation from registers
	input  wire logic        reg_usb_enable_i,                // USB switch from registers
	output logic             device_active_o,
	output logic             bus_enable_o,
	output logic             bus_io_1v8_o,
	output logic             test_mode_o,
	output logic             bus_clock_o,                     // Clock line to bus core
	output logic             bus_data_o,                      // Data line to bus core
	output logic [3:0]       bus_addr_o,                      // Address bits from straps
	output logic             flip_o,
	output logic             usb_enable_o,
	output logic             dp_enable_o,
	output logic             dp_lanes_enable_o,
	output logic             aux_snoop_o,
	output logic             aux_p_to_sbu1_o,                 // AUXp on sideband 1, AUXn on 2
	output logic             aux_p_to_sbu2_o,                 // AUXp on sideband 2, AUXn on 1
	output gain_t            usb_up_gain_o,
	output gain_t            dp_gain_o,
	output gain_t            usb_down_gain_o
);
	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------
	// Joint decode of two four-level straps into a 16-step gain index
	function automatic gain_t gain_of(input level_t hi, input level_t lo);
		gain_of = {hi, lo};
	endfunction : gain_of

	// Interface-select decode
	function automatic bus_mode_e mode_of(input level_t sel);
		case (sel)
			`LVL_ZERO: mode_of = MODE_PIN;
			`LVL_R:    mode_of = MODE_TEST;
			`LVL_F:    mode_of = MODE_BUS_18;
			default:   mode_of = MODE_BUS_33;
		endcase
	endfunction : mode_of

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	localparam int SW = 17;    // Strap and pin bits gathered
	logic [SW-1:0] raw;        // Unsynchronised pins
	logic [SW-1:0] sync1_reg;  // First stage, read only by second
	logic [SW-1:0] sync2_reg;  // Safe to use
	logic [4:0]    ctl_raw;
	logic [4:0]    dp_function_enable_reg;
	logic [4:0]    ctl2_reg;

	assign raw = {enable_i, bus_select_i, usb_up_eq_sel_hi_i, usb_up_eq_sel_lo_i,
		dp_rx_eq_sel_hi_i, dp_rx_eq_sel_lo_addr_b1_i, usb_down_eq_sel_hi_i,
		usb_down_eq_sel_lo_addr_b0_i, flip_or_bus_clock_i, usb_switch_or_bus_data_i};
	assign ctl_raw = {dp_function_enable_i, hot_plug_detect_in_i, reg_dp_enable_i,
		reg_flip_i, reg_usb_enable_i};

	// Two flops on every pin; control lines from the bus core are
	// treated the same since their clock is not known here
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			dp_function_enable_reg  <= '0;
			ctl2_reg  <= '0;
		end else begin
			sync1_reg <= raw;
			sync2_reg <= sync1_reg;
			dp_function_enable_reg  <= ctl_raw;
			ctl2_reg  <= dp_function_enable_reg;
		end
	end

	logic       en_s;
	logic [1:0] sel_s;
	logic [1:0] ueh_s, uel_s, dph_s, dpl_s, udh_s, udl_s;
	logic       flip_s, usw_s;
	logic       dpen_s, hpd_s, rdp_s, rflip_s, rusb_s;
	assign {en_s, sel_s, ueh_s, uel_s, dph_s, dpl_s, udh_s, udl_s, flip_s, usw_s} = sync2_reg;
	assign {dpen_s, hpd_s, rdp_s, rflip_s, rusb_s} = ctl2_reg;

	// ----------------------------------------------------------------
	// Strap capture
	// ----------------------------------------------------------------
	logic   en_d_reg;       // Enable one cycle ago, for edge detect
	logic   en_rise;
	level_t sel_reg;
	level_t ueh_reg, uel_reg, dph_reg, dpl_reg, udh_reg, udl_reg;

	assign en_rise = en_s && !en_d_reg;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			en_d_reg <= 1'b0;
		end else begin
			en_d_reg <= en_s;
		end
	end

	// Straps load only on the enable edge; bus registers live outside
	// so this capture cannot disturb them
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sel_reg <= `LVL_ZERO;
			ueh_reg <= `LVL_ZERO;
			uel_reg <= `LVL_ZERO;
			dph_reg <= `LVL_ZERO;
			dpl_reg <= `LVL_ZERO;
			udh_reg <= `LVL_ZERO;
			udl_reg <= `LVL_ZERO;
		end else if (en_rise) begin
			sel_reg <= sel_s;
			ueh_reg <= ueh_s;
			uel_reg <= uel_s;
			dph_reg <= dph_s;
			dpl_reg <= dpl_s;
			udh_reg <= udh_s;
			udl_reg <= udl_s;
		end                            // Otherwise hold
	end

	// ----------------------------------------------------------------
	// Mode decode and gating
	// ----------------------------------------------------------------
	bus_mode_e mode;
	logic      pin_mode;
	logic      active;
	assign mode     = mode_of(sel_reg);
	assign pin_mode = (mode == MODE_PIN);
	assign active   = pin_mode ? en_s : 1'b1;

	// ----------------------------------------------------------------
	// Hot-plug qualification
	// ----------------------------------------------------------------
	logic hpd_lost;
	hpd_qualifier u_hpd (
		.clk_i      (clk_i),
		.nrst_i     (nrst_i),
		.hpd_sync_i (hpd_s),
		.hpd_lost_o (hpd_lost)
	);

	// ----------------------------------------------------------------
	// Registered outputs
	// ----------------------------------------------------------------
	logic dp_en_next;
	logic flip_next;
	logic usb_next;
	assign dp_en_next = pin_mode ? dpen_s : rdp_s;
	assign flip_next  = pin_mode ? flip_s : rflip_s;
	assign usb_next   = pin_mode ? usw_s : rusb_s;

	// Mode and routing controls
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			device_active_o   <= 1'b0;
			bus_enable_o      <= 1'b0;
			bus_io_1v8_o      <= 1'b0;
			test_mode_o       <= 1'b0;
			flip_o            <= 1'b0;
			usb_enable_o      <= 1'b0;
			dp_enable_o       <= 1'b0;
			dp_lanes_enable_o <= 1'b0;
			aux_snoop_o       <= 1'b0;
			aux_p_to_sbu1_o   <= 1'b0;
			aux_p_to_sbu2_o   <= 1'b0;
		end else begin
			device_active_o   <= active;
			bus_enable_o      <= !pin_mode;
			bus_io_1v8_o      <= (mode == MODE_BUS_18);
			test_mode_o       <= (mode == MODE_TEST);
			flip_o            <= active && flip_next;
			usb_enable_o      <= active && usb_next;
			dp_enable_o       <= active && dp_en_next;
			// Lanes drop on lost hot-plug; sideband switch stays closed
			dp_lanes_enable_o <= active && dp_en_next && !hpd_lost;
			aux_snoop_o       <= active && dp_en_next;
			aux_p_to_sbu1_o   <= active && dp_en_next && !flip_next;
			aux_p_to_sbu2_o   <= active && dp_en_next && flip_next;
		end
	end

	// Shared pins towards the bus core, quiet in pin mode
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			bus_clock_o <= 1'b0;
			bus_data_o  <= 1'b0;
			bus_addr_o  <= 4'h0;
		end else begin
			bus_clock_o <= !pin_mode && flip_s;
			bus_data_o  <= !pin_mode && usw_s;
			// Board keeps address strap at 0 or F for 1.8 V
			bus_addr_o  <= pin_mode ? 4'h0 : {dpl_reg, udl_reg};
		end
	end

	// Equalizer gains
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			usb_up_gain_o   <= 4'h0;
			dp_gain_o       <= 4'h0;
			usb_down_gain_o <= 4'h0;
		end else begin
			// Top codes clamp to the upstream ceiling
			usb_up_gain_o   <= (gain_of(ueh_reg, uel_reg) > `GAIN_MAX_USB_UP) ?
				`GAIN_MAX_USB_UP : gain_of(ueh_reg, uel_reg);
			dp_gain_o       <= gain_of(dph_reg, dpl_reg);
			usb_down_gain_o <= gain_of(udh_reg, udl_reg);
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence s_rise;
		en_rise;
	endsequence
	property p_capture;
		@(posedge clk_i) disable iff (!nrst_i) s_rise |=> (sel_reg == $past(sel_s));
	endproperty
	a_capture: assert property (p_capture) else $error("strap not captured");
	property p_hold;
		@(posedge clk_i) disable iff (!nrst_i) !en_rise |=> $stable(sel_reg) && $stable(dph_reg);
	endproperty
	a_hold: assert property (p_hold) else $error("strap changed between edges");
	property p_gate;
		@(posedge clk_i) disable iff (!nrst_i) (pin_mode && !en_s) |=> !device_active_o;
	endproperty
	a_gate: assert property (p_gate) else $error("pin mode disable ignored");
	property p_nogate;
		@(posedge clk_i) disable iff (!nrst_i) !pin_mode |=> device_active_o;
	endproperty
	a_nogate: assert property (p_nogate) else $error("bus mode disabled by enable");
	property p_mode;
		@(posedge clk_i) disable iff (!nrst_i) 1'b1 |=> bus_enable_o == ($past(sel_reg) != `LVL_ZERO);
	endproperty
	a_mode: assert property (p_mode) else $error("bus enable decode wrong");
	property p_lanes;
		@(posedge clk_i) disable iff (!nrst_i) hpd_lost |=> !dp_lanes_enable_o;
	endproperty
	a_lanes: assert property (p_lanes) else $error("lanes on after hot-plug loss");
	property p_dp_pin;
		@(posedge clk_i) disable iff (!nrst_i) (pin_mode && en_s && dpen_s) |=> dp_enable_o;
	endproperty
	a_dp_pin: assert property (p_dp_pin) else $error("pin enable not followed");
	property p_dp_reg;
		@(posedge clk_i) disable iff (!nrst_i) (!pin_mode && !rdp_s) |=> !dp_enable_o;
	endproperty
	a_dp_reg: assert property (p_dp_reg) else $error("register disable ignored");
	property p_up_max;
		@(posedge clk_i) disable iff (!nrst_i) usb_up_gain_o <= `GAIN_MAX_USB_UP;
	endproperty
	a_up_max: assert property (p_up_max) else $error("upstream gain above ceiling");
	property p_aux;
		@(posedge clk_i) disable iff (!nrst_i) !(aux_p_to_sbu1_o && aux_p_to_sbu2_o);
	endproperty
	a_aux: assert property (p_aux) else $error("aux routed both ways");
	property p_addr;
		@(posedge clk_i) disable iff (!nrst_i) pin_mode |=> (bus_addr_o == 4'h0);
	endproperty
	a_addr: assert property (p_addr) else $error("address bits set in pin mode");
	property p_bus_quiet;
		@(posedge clk_i) disable iff (!nrst_i) pin_mode |=> !bus_clock_o && !bus_data_o;
	endproperty
	a_bus_quiet: assert property (p_bus_quiet) else $error("bus lines active in pin mode");
endmodule : alt_mode_switch_pin_control
`default_nettype wire

// >>> verification/strap_board_model.sv
// Purpose: Board straps, pin controls and display sink hot-plug seen by the pin control block.
// Assumes: Tasks are called just after a falling clock edge by the bench.
// Notes:   Straps are plain levels; no pull effects are modelled.
`timescale 1ns/1ps
`include "mode_ctl_consts.svh"
`default_nettype none
module strap_board_model
	import mode_ctl_pkg::*;
(
	output var logic   enable_o,     // Device enable pin
	output var level_t sel_o,        // Interface-select strap
	output var level_t up_hi_o,      // Upstream gain straps
	output var level_t up_lo_o,
	output var level_t dp_hi_o,      // Display gain straps
	output var level_t dp_lo_o,
	output var level_t dn_hi_o,      // Downstream gain straps
	output var level_t dn_lo_o,
	output var logic   flip_o,       // Flip or bus clock pin
	output var logic   sw_o,         // Switch or bus data pin
	output var logic   dp_en_o,      // Display enable pin
	output var logic   hpd_o         // Hot-plug from the sink
);
	// Quiet board at time zero: disabled, pin mode, sink attached
	initial begin
		{enable_o, sel_o, up_hi_o, up_lo_o, dp_hi_o, dp_lo_o, dn_hi_o, dn_lo_o} = '0;
		{flip_o, sw_o, dp_en_o, hpd_o} = 4'h1;
	end
	task automatic set_straps(input level_t s, uh, ul, dh, dl, nh, nl);
		{sel_o, up_hi_o, up_lo_o, dp_hi_o, dp_lo_o, dn_hi_o} = {s, uh, ul, dh, dl, nh};
		// A 1.8 V bus board only straps the low address pin to F or 0
		dn_lo_o = (s == `LVL_F && nl != `LVL_F) ? `LVL_ZERO : nl;
	endtask : set_straps
	task automatic set_pins(input logic e, f, w, d, h);
		{enable_o, flip_o, sw_o, dp_en_o, hpd_o} = {e, f, w, d, h};
	endtask : set_pins
endmodule : strap_board_model
`default_nettype wire

// >>> verification/alt_mode_switch_pin_control_bench.sv
// Purpose: Self-checking bench for the alt-mode switch pin control block.
// Assumes: Outputs settle within four cycles of a pin edge; five are allowed.
// Notes:   The 2 ms hot-plug limit is too long to reach here; only its restart is run.
`timescale 1ns/1ps
`include "mode_ctl_consts.svh"
`default_nettype none
module alt_mode_switch_pin_control_bench;
	import mode_ctl_pkg::*;
	logic   clk_i = 1'b0, nrst_i = 1'b0;                 // Clock and reset
	logic   enable_i, flip_or_bus_clock_i, usb_switch_or_bus_data_i, dp_function_enable_i, hot_plug_detect_in_i;
	level_t bus_select_i, usb_up_eq_sel_hi_i, usb_up_eq_sel_lo_i, dp_rx_eq_sel_hi_i;
	level_t dp_rx_eq_sel_lo_addr_b1_i, usb_down_eq_sel_hi_i, usb_down_eq_sel_lo_addr_b0_i;
	logic   reg_dp_enable_i = 1'b1, reg_flip_i = 1'b0, reg_usb_enable_i = 1'b0; // Register core stand-in
	logic   device_active_o, bus_enable_o, bus_io_1v8_o, test_mode_o, bus_clock_o, bus_data_o;
	logic   flip_o, usb_enable_o, dp_enable_o, dp_lanes_enable_o, aux_snoop_o, aux_p_to_sbu1_o, aux_p_to_sbu2_o;
	logic [3:0] bus_addr_o;                              // Address from straps
	gain_t  usb_up_gain_o, dp_gain_o, usb_down_gain_o;   // Decoded gains
	int     num_errors = 0, tests_run = 0;
	// ------------------------------------------------------------
	// Clock, design and board
	// ------------------------------------------------------------
	always #2 clk_i = ~clk_i;
	alt_mode_switch_pin_control i_dut (.clk_i, .nrst_i, .enable_i, .bus_select_i, .usb_up_eq_sel_hi_i,
		.usb_up_eq_sel_lo_i, .dp_rx_eq_sel_hi_i, .dp_rx_eq_sel_lo_addr_b1_i, .usb_down_eq_sel_hi_i,
		.usb_down_eq_sel_lo_addr_b0_i, .flip_or_bus_clock_i, .usb_switch_or_bus_data_i, .dp_function_enable_i,
		.hot_plug_detect_in_i, .reg_dp_enable_i, .reg_flip_i, .reg_usb_enable_i, .device_active_o, .bus_enable_o,
		.bus_io_1v8_o, .test_mode_o, .bus_clock_o, .bus_data_o, .bus_addr_o, .flip_o, .usb_enable_o, .dp_enable_o,
		.dp_lanes_enable_o, .aux_snoop_o, .aux_p_to_sbu1_o, .aux_p_to_sbu2_o, .usb_up_gain_o, .dp_gain_o,
		.usb_down_gain_o);
	strap_board_model i_board (.enable_o(enable_i), .sel_o(bus_select_i), .up_hi_o(usb_up_eq_sel_hi_i),
		.up_lo_o(usb_up_eq_sel_lo_i), .dp_hi_o(dp_rx_eq_sel_hi_i), .dp_lo_o(dp_rx_eq_sel_lo_addr_b1_i),
		.dn_hi_o(usb_down_eq_sel_hi_i), .dn_lo_o(usb_down_eq_sel_lo_addr_b0_i), .flip_o(flip_or_bus_clock_i),
		.sw_o(usb_switch_or_bus_data_i), .dp_en_o(dp_function_enable_i), .hpd_o(hot_plug_detect_in_i));
	// ------------------------------------------------------------
	// Shared helpers
	// ------------------------------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_i);
	endtask : cyc
	task automatic chk(input logic [3:0] got, input logic [3:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Low enable long enough for a fresh edge, then raise it to capture
	task automatic capture(input level_t s, uh, ul, dh, dl, nh, nl);
		i_board.set_pins(1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
		i_board.set_straps(s, uh, ul, dh, dl, nh, nl);
		cyc(4);
		i_board.set_pins(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
		cyc(5);
	endtask : capture
	task automatic tally_and_finish;
		$display("Counts: comparisons=%0d mismatches=%0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	// Every select code; enable low only disables in pin mode
	task automatic t_modes;
		logic [3:0] mexp [4] = '{4'h0, 4'h5, 4'h3, 4'h1};   // {0, test, 1.8 V, bus} per select code
		for (int s = 0; s < 4; s++) begin
			capture(level_t'(s), 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0);
			chk({1'b0, test_mode_o, bus_io_1v8_o, bus_enable_o}, mexp[s]);
			i_board.set_pins(1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
			cyc(5);
			chk({3'h0, device_active_o}, {3'h0, s != 0});
		end
	endtask : t_modes
	// Gain tables per group, clamp, address bits, and hold between edges
	task automatic t_gains;
		logic [15:0] tv [4] = '{16'h0000, 16'h3FFF, 16'hEBCA, 16'hAA1E};
		for (int i = 0; i < 4; i++) begin
			capture(level_t'(i), tv[i][13:12], tv[i][11:10], tv[i][9:8], tv[i][7:6], tv[i][5:4], tv[i][3:2]);
			chk(usb_up_gain_o, (tv[i][13:10] > 4'hB) ? 4'hB : tv[i][13:10]);
			chk(dp_gain_o, tv[i][9:6]);
			chk(usb_down_gain_o, tv[i][5:2]);
			chk(bus_addr_o, (i == 0) ? 4'h0 : {tv[i][7:6], tv[i][3:2]});
		end
		i_board.set_straps(2'h0, 2'h0, 2'h0, 2'h3, 2'h3, 2'h3, 2'h3);
		cyc(6);
		chk({bus_io_1v8_o, bus_enable_o, 2'h0}, 4'h4);
		chk(dp_gain_o, 4'h8);
	endtask : t_gains
	// Shared pins and display enable in both modes, sideband routing in pin mode
	task automatic t_pins;
		capture(2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0);
		for (int k = 0; k < 8; k++) begin
			i_board.set_pins(1'b1, k[0], k[1], k[2], 1'b1);
			cyc(5);
			chk({usb_enable_o, flip_o}, {2'h0, k[1:0]});
			chk({dp_lanes_enable_o, dp_enable_o}, {2'h0, k[2], k[2]});
			chk({aux_p_to_sbu2_o, aux_p_to_sbu1_o}, {2'h0, k[2] & k[0], k[2] & ~k[0]});
			chk({3'h0, aux_snoop_o}, {3'h0, k[2]});
		end
		capture(2'h3, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0);
		for (int k = 0; k < 2; k++) begin
			{reg_dp_enable_i, reg_flip_i, reg_usb_enable_i} = {k[0], 2'b10};
			i_board.set_pins(1'b1, ~k[0], ~k[0], ~k[0], 1'b1);
			cyc(5);
			chk({dp_enable_o, bus_data_o, bus_clock_o}, {1'b0, k[0], ~k[0], ~k[0]});
			chk({usb_enable_o, flip_o}, 4'h1);
		end
	endtask : t_pins
	// Hot-plug lows shorter than the limit keep lanes and sideband up
	task automatic t_hpd;
		capture(2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0);
		for (int k = 0; k < 2; k++) begin
			i_board.set_pins(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
			cyc(30000);
			chk({aux_p_to_sbu1_o, dp_lanes_enable_o}, 4'h3);
			i_board.set_pins(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
			cyc(10);
		end
	endtask : t_hpd
	// ------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		cyc(3);
		chk({device_active_o, bus_enable_o, dp_lanes_enable_o, flip_o}, 4'h0);
		cyc(3);
		nrst_i = 1'b1;
		cyc(2);
		t_modes();
		t_gains();
		t_pins();
		t_hpd();
		tally_and_finish();
	end
	// Whole run is well under 70000 cycles
	initial begin
		#320000;
		num_errors++;
		tally_and_finish();
	end
endmodule : alt_mode_switch_pin_control_bench
`default_nettype wire
